//--- hw/pwm_corr_pkg.sv
package pwm_corr_pkg;
    // byte offsets on the register bus
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  MODULUS_OFS   = 8'h04;
    localparam logic [7:0]  DEADTIME_OFS  = 8'h08;
    localparam logic [7:0]  CONFIG_OFS    = 8'h0C;
    localparam logic [7:0]  STATUS_OFS    = 8'h10;
    localparam logic [7:0]  VALUE0_OFS    = 8'h20;
    localparam logic [7:0]  VALUE_STEP    = 8'h04;

    // control register fields
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_SEP_BIT    = 1;
    localparam int CTRL_CENTER_BIT = 2;
    localparam int CTRL_METHOD_LSB = 3;
    localparam int CTRL_MANUAL_LSB = 5;
    localparam int CTRL_LOAD_OK_INTERLOCK_BIT   = 8;

    // config register fields
    localparam int CFG_TOP_BIT     = 0;
    localparam int CFG_BOT_BIT     = 1;

    // status register fields
    localparam int STAT_SAMPLE_LSB = 0;
    localparam int STAT_LATCH_LSB  = 6;
    localparam int STAT_SEL_LSB    = 9;

    // sense method codes
    localparam logic [1:0]  METHOD_DEADTIME = 2'h2;
    localparam logic [1:0]  METHOD_CYCLE    = 2'h3;

    // reset values
    localparam logic [11:0] MODULUS_RST   = 12'h0FF;
    localparam logic [7:0]  DEADTIME_RST  = 8'h00;
    localparam logic [15:0] VALUE_RST     = 16'h0000;
    localparam logic [2:0]  MANUAL_RST    = 3'h0;
    localparam logic [1:0]  METHOD_RST    = 2'h0;

    // value clamping
    localparam logic [11:0] VALUE_MAX     = 12'hFFF;
endpackage

//--- hw/pwm_topbottom_correction.sv
`timescale 1ns/100ps
`default_nettype none

module pwm_topbottom_correction (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // current sense pins, asynchronous, active low naming
    input  wire logic [2:0]  current_sense_in_n,
    // pwm pins
    output logic [5:0]       pwm_out
);

    // registers
    logic        generator_enable_r;
    logic        pair_mode_separate_r;
    logic        center_r;
    logic [1:0]  sense_method_select_r;
    logic [2:0]  manual_half_select_r;
    logic        load_ok_interlock_r;
    logic [11:0] modulus_r;
    logic [7:0]  deadtime_r;
    logic        deadtime_done_r;
    logic        top_invert_r;
    logic        bottom_invert_r;
    logic        config_done_r;
    logic [15:0] pulse_value_reg_r [6];
    logic [11:0] value_used_r [6];
    logic [5:0]  sense_sample_bits_r;
    logic [2:0]  sense_latch_r;
    logic [2:0]  sel_r;
    logic [2:0]  sense_s1_r;
    logic [2:0]  sense_s2_r;
    logic [11:0] cnt_r;
    logic        down_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic [5:0]  pwm_out_r;

    // bus decode
    wire        access    = psel & penable;
    wire        take      = access & pready_r;
    wire        wr        = take & pwrite;
    wire [7:0]  val_rel   = paddr - pwm_corr_pkg::VALUE0_OFS;
    wire        val_hit   = (paddr >= pwm_corr_pkg::VALUE0_OFS) && (val_rel[1:0] == 2'h0)
                            && (val_rel[7:2] < 6'h06);
    wire [2:0]  val_idx   = val_rel[4:2];
    wire        hit_ctrl  = paddr == pwm_corr_pkg::CTRL_OFS;
    wire        hit_mod   = paddr == pwm_corr_pkg::MODULUS_OFS;
    wire        hit_dt    = paddr == pwm_corr_pkg::DEADTIME_OFS;
    wire        hit_cfg   = paddr == pwm_corr_pkg::CONFIG_OFS;
    wire        hit_stat  = paddr == pwm_corr_pkg::STATUS_OFS;
    wire        mapped    = hit_ctrl | hit_mod | hit_dt | hit_cfg | hit_stat | val_hit;
    // status is read-only; writes to it are refused
    wire        bad       = !mapped || (pwrite && hit_stat);

    wire [31:0] ctrl_word = {23'h000000, load_ok_interlock_r, manual_half_select_r,
                             sense_method_select_r, center_r, pair_mode_separate_r,
                             generator_enable_r};
    wire [31:0] stat_word = {20'h00000, sel_r, sense_latch_r, sense_sample_bits_r};
    wire [31:0] rdata     = hit_ctrl ? ctrl_word :
                            hit_mod  ? {20'h00000, modulus_r} :
                            hit_dt   ? {24'h000000, deadtime_r} :
                            hit_cfg  ? {30'h00000000, bottom_invert_r, top_invert_r} :
                            hit_stat ? stat_word :
                            val_hit  ? {16'h0000, pulse_value_reg_r[val_idx]} :
                                       32'h00000000;

    // one wait state: the first access cycle loads the answer, which stands in the second
    wire        answer     = access & !pready_r;
    wire [31:0] prdata_nxt = (answer & !pwrite) ? rdata : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= answer;
            pslverr_r <= answer & bad;
            prdata_r  <= prdata_nxt;
        end
    end

    // counter
    // center mode turns at both ends without dwelling: a period is 2*(MOD-1) clocks
    wire [11:0] mod_m1    = modulus_r - 12'h001;
    wire        at_top    = cnt_r >= mod_m1;
    wire        half_pls  = generator_enable_r & center_r & !down_r & at_top;
    wire        end_pls   = generator_enable_r & (center_r ? (down_r & (cnt_r == 12'h000))
                                                          : at_top);
    wire        cycle_end = end_pls;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= 12'h000;
            down_r <= 1'b0;
        end else if (!generator_enable_r) begin
            cnt_r  <= 12'h000;
            down_r <= 1'b0;
        end else if (!center_r) begin
            cnt_r  <= at_top ? 12'h000 : cnt_r + 12'h001;
            down_r <= 1'b0;
        end else if (!down_r) begin
            down_r <= at_top;
            cnt_r  <= at_top ? cnt_r - {11'h000, (cnt_r != 12'h000)} : cnt_r + 12'h001;
        end else begin
            down_r <= cnt_r != 12'h000;
            cnt_r  <= (cnt_r == 12'h000) ? cnt_r + {11'h000, !at_top} : cnt_r - 12'h001;
        end
    end

    // control, config, dead-time and load-ok
    wire wr_ctrl  = wr & hit_ctrl;
    wire wr_mod   = wr & hit_mod;
    wire load_ok_interlock_set = wr_ctrl & pwdata[pwm_corr_pkg::CTRL_LOAD_OK_INTERLOCK_BIT];
    // load-ok gates the value copies only; the selection moves at every cycle end
    wire load_now = !generator_enable_r | (cycle_end & load_ok_interlock_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            generator_enable_r    <= 1'b0;
            pair_mode_separate_r  <= 1'b0;
            center_r              <= 1'b0;
            sense_method_select_r <= pwm_corr_pkg::METHOD_RST;
            manual_half_select_r  <= pwm_corr_pkg::MANUAL_RST;
            modulus_r             <= pwm_corr_pkg::MODULUS_RST;
        end else begin
            if (wr_ctrl) begin
                generator_enable_r    <= pwdata[pwm_corr_pkg::CTRL_EN_BIT];
                pair_mode_separate_r  <= pwdata[pwm_corr_pkg::CTRL_SEP_BIT];
                center_r              <= pwdata[pwm_corr_pkg::CTRL_CENTER_BIT];
                // method takes effect at once, no shadow copy
                sense_method_select_r <= pwdata[pwm_corr_pkg::CTRL_METHOD_LSB +: 2];
                // buffered copy; only moved into use at the cycle end
                manual_half_select_r  <= pwdata[pwm_corr_pkg::CTRL_MANUAL_LSB +: 3];
            end
            if (wr_mod) begin
                modulus_r <= pwdata[11:0];
            end
        end
    end

    // software set wins over the hardware clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_ok_interlock_r <= 1'b0;
        end else if (load_ok_interlock_set) begin
            load_ok_interlock_r <= 1'b1;
        end else if (cycle_end) begin
            load_ok_interlock_r <= 1'b0;
        end
    end

    // later writes are dropped without an error, so a stray store cannot flip the bridge
    wire dt_first  = wr & hit_dt & !deadtime_done_r;
    wire cfg_first = wr & hit_cfg & !config_done_r;

    // write-once option registers, locked by the first write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deadtime_r      <= pwm_corr_pkg::DEADTIME_RST;
            deadtime_done_r <= 1'b0;
            top_invert_r    <= 1'b0;
            bottom_invert_r <= 1'b0;
            config_done_r   <= 1'b0;
        end else begin
            if (dt_first) begin
                deadtime_r      <= pwdata[7:0];
                deadtime_done_r <= 1'b1;
            end
            if (cfg_first) begin
                top_invert_r    <= pwdata[pwm_corr_pkg::CFG_TOP_BIT];
                bottom_invert_r <= pwdata[pwm_corr_pkg::CFG_BOT_BIT];
                config_done_r   <= 1'b1;
            end
        end
    end

    // sense pin synchroniser
    // the pins are asynchronous to pclk; nothing but the second stage reads the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_s1_r <= 3'h0;
            sense_s2_r <= 3'h0;
        end else begin
            sense_s1_r <= current_sense_in_n;
            sense_s2_r <= sense_s1_r;
        end
    end

    // value registers and their in-use copies, clamped to the counter range
    // negative values keep a pin inactive all period, oversized ones active all period
    logic [5:0] cmp;
    genvar c;
    generate
        for (c = 0; c < 6; c++) begin : g_chan
            wire        wr_val  = wr & val_hit & (val_idx == 3'(c));
            wire [11:0] clamped = pulse_value_reg_r[c][15] ? 12'h000 :
                                  (pulse_value_reg_r[c][14:12] != 3'h0) ?
                                  pwm_corr_pkg::VALUE_MAX : pulse_value_reg_r[c][11:0];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pulse_value_reg_r[c] <= pwm_corr_pkg::VALUE_RST;
                    value_used_r[c]      <= 12'h000;
                end else begin
                    if (wr_val) begin
                        pulse_value_reg_r[c] <= pwdata[15:0];
                    end
                    if (load_now) begin
                        value_used_r[c] <= clamped;
                    end
                end
            end
            assign cmp[c] = cnt_r < value_used_r[c];
        end
    endgenerate

    // pairs: selection, dead-time, sense sampling, polarity
    logic [7:0] dtc_r  [3];
    logic [2:0] raw_q_r;
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_pair
            // bit 0 picks the odd register (index 2p), 1 the even one
            wire raw       = sel_r[p] ? cmp[2*p+1] : cmp[2*p];
            wire in_dead   = dtc_r[p] != 8'h00;
            wire dead_done = dtc_r[p] == 8'h01;
            // cycle-based sampling point depends on alignment
            wire cyc_pt    = center_r ? half_pls : end_pls;
            wire top_act   = pair_mode_separate_r ? cmp[2*p]   : (raw_q_r[p] & !in_dead);
            wire bot_act   = pair_mode_separate_r ? cmp[2*p+1] : (!raw_q_r[p] & !in_dead);
            wire new_sel   = sense_method_select_r[1] ? sense_latch_r[p]
                                                      : manual_half_select_r[p];
            wire tog       = generator_enable_r & (raw != raw_q_r[p]);
            // the closing dead-time picks the sample slot; a zero dead-time samples nothing
            wire smp_on    = dead_done & !pair_mode_separate_r & raw_q_r[p];
            wire smp_off   = dead_done & !pair_mode_separate_r & !raw_q_r[p];
            wire latch_dt  = (sense_method_select_r == pwm_corr_pkg::METHOD_DEADTIME) & in_dead;
            wire latch_cyc = (sense_method_select_r == pwm_corr_pkg::METHOD_CYCLE) & cyc_pt;
            // pins rest at the polarity level while the generator is off
            wire top_nxt   = (generator_enable_r & top_act) ^ top_invert_r;
            wire bot_nxt   = (generator_enable_r & bot_act) ^ bottom_invert_r;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    raw_q_r[p] <= 1'b0;
                    dtc_r[p]   <= 8'h00;
                end else begin
                    raw_q_r[p] <= raw;
                    // any transition of the top drive starts the dead-time, which forces both sides off in complementary mode only
                    if (tog) begin
                        dtc_r[p] <= deadtime_r;
                    end else if (in_dead) begin
                        dtc_r[p] <= dtc_r[p] - 8'h01;
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sense_latch_r[p]           <= 1'b0;
                    sense_sample_bits_r[2*p]   <= 1'b0;
                    sense_sample_bits_r[2*p+1] <= 1'b0;
                    sel_r[p]                   <= 1'b0;
                end else if (!generator_enable_r) begin
                    // no sense history before enable, so odd registers lead
                    sense_latch_r[p] <= 1'b0;
                    sel_r[p]         <= 1'b0;
                end else begin
                    // two samples per period, one per dead-time edge
                    if (smp_on) begin
                        sense_sample_bits_r[2*p]   <= sense_s2_r[p];
                    end
                    if (smp_off) begin
                        sense_sample_bits_r[2*p+1] <= sense_s2_r[p];
                    end
                    // dead-time method latches only while the dead-time counter runs, so none at 0%/100%
                    if (latch_dt) begin
                        sense_latch_r[p] <= sense_s2_r[p];
                    end
                    if (latch_cyc) begin
                        sense_latch_r[p] <= sense_s2_r[p];
                    end
                    // selection changes only at the cycle boundary
                    if (cycle_end) begin
                        sel_r[p] <= new_sel;
                    end
                end
            end

            // inactive level follows polarity too
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pwm_out_r[2*p]   <= 1'b0;
                    pwm_out_r[2*p+1] <= 1'b0;
                end else begin
                    pwm_out_r[2*p]   <= top_nxt;
                    pwm_out_r[2*p+1] <= bot_nxt;
                end
            end
        end
    endgenerate

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign pwm_out = pwm_out_r;

endmodule // pwm_topbottom_correction

`default_nettype wire

//--- test/pwm_sense_drive.sv
`timescale 1ns/100ps
`default_nettype none

module pwm_sense_drive (
    // clock
    input  wire logic       pclk,
    // load current per pair, 1 = negative, and comparator speed
    input  wire logic [2:0] current_neg,
    input  wire logic       slow,
    // comparator outputs
    output logic [2:0]      current_sense_in_n
);
    logic [2:0] lag_r [4] = '{default: 3'h0};

    // a slow comparator settles some clocks after the current turns
    always_ff @(posedge pclk) begin
        lag_r[0] <= current_neg;
        for (int i = 1; i < 4; i++) begin
            lag_r[i] <= lag_r[i - 1];
        end
    end

    // high for negative current, low for positive
    assign current_sense_in_n = slow ? lag_r[3] : lag_r[0];
endmodule // pwm_sense_drive

`default_nettype wire

//--- test/pwm_topbottom_correction_props.sv
`timescale 1ns/100ps
`default_nettype none

module pwm_topbottom_correction_props (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // pins
    input  wire logic [2:0]  current_sense_in_n,
    input  wire logic [5:0]  pwm_out
);
    logic [1:0] inv_r;
    logic       once_r;
    logic       en_r;
    logic       sep_r;
    logic [2:0] quiet_r;
    wire        wr_ok = psel && penable && pready && pwrite && !pslverr;
    wire [5:0]  act   = pwm_out ^ {3{inv_r}};
    wire        hole  = (paddr > 8'h34) || (paddr > 8'h10 && paddr < 8'h20);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // only software settings are tracked; internal state stays hidden
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inv_r   <= 2'h0;
            once_r  <= 1'b0;
            en_r    <= 1'b0;
            sep_r   <= 1'b0;
            quiet_r <= 3'h0;
        end else begin
            if (wr_ok && paddr == pwm_corr_pkg::CONFIG_OFS && !once_r) begin
                inv_r  <= pwdata[1:0];
                once_r <= 1'b1;
            end
            if (wr_ok && paddr == pwm_corr_pkg::CTRL_OFS) begin
                en_r  <= pwdata[pwm_corr_pkg::CTRL_EN_BIT];
                sep_r <= pwdata[pwm_corr_pkg::CTRL_SEP_BIT];
            end
            quiet_r <= (wr_ok || en_r) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
        end
    end

    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held too long");
    property p_rdy_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("wait state not exactly one");
    property p_rdy_cause; pready |-> $past(psel) && $past(penable) && penable; endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("pready without access phase");
    property p_err_hole; pready && hole |-> pslverr && prdata == 32'h0; endproperty
    a_err_hole: assert property (p_err_hole) else $error("unmapped access not refused");
    property p_err_stat; pready && pwrite && paddr == pwm_corr_pkg::STATUS_OFS |-> pslverr;
    endproperty
    a_err_stat: assert property (p_err_stat) else $error("status write not refused");
    property p_quiet_bus; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    a_quiet_bus: assert property (p_quiet_bus) else $error("bus outputs outside answer");
    property p_idle_lvl; quiet_r == 3'h7 |-> pwm_out == {3{inv_r}}; endproperty
    a_idle_lvl: assert property (p_idle_lvl) else $error("idle level wrong");
    property p_pair_excl; en_r && !sep_r |-> (act & (act >> 1) & 6'h15) == 6'h0; endproperty
    a_pair_excl: assert property (p_pair_excl) else $error("both of a pair active");

    c_err: cover property (pready && pslverr);
    c_top: cover property (en_r && !sep_r && act[0]);
    c_bot: cover property (en_r && !sep_r && act[1]);
endmodule // pwm_topbottom_correction_props

bind pwm_topbottom_correction pwm_topbottom_correction_props i_pwm_topbottom_correction_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .current_sense_in_n(current_sense_in_n), .pwm_out(pwm_out));

`default_nettype wire

//--- test/pwm_topbottom_correction_bench.sv
`timescale 1ns/100ps
`default_nettype none

module pwm_topbottom_correction_bench;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  sense_n;
    logic [5:0]  pwm_out;
    logic [2:0]  neg_r   = 3'h0;
    logic        slow_r  = 1'b0;
    logic [2:0]  s;
    logic [31:0] st;
    logic        er;
    int          miscompares     = 0;
    int          samples_checked = 0;
    int          cfg_m           = -1;
    int          dt_m            = -1;
    integer      seed            = 32'hE6BC2B8D;
    logic [7:0]  rst_a [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
    logic [31:0] rst_v [6] = '{32'h0, {20'h0, pwm_corr_pkg::MODULUS_RST}, 0, 0, 0, 0};

    always #50 pclk = ~pclk;

    pwm_topbottom_correction i_pwm_topbottom_correction (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .current_sense_in_n(sense_n), .pwm_out(pwm_out));
    pwm_sense_drive i_pwm_sense_drive (
        .pclk(pclk), .current_neg(neg_r), .slow(slow_r), .current_sense_in_n(sense_n));

    task automatic test_done;
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_err(input logic exp, input logic got);
        chk("error flag", {31'h0, exp}, {31'h0, got});
    endtask

    task automatic chk_pins(input string what, input logic [5:0] exp);
        chk(what, {26'h0, exp}, {26'h0, pwm_out});
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic e);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // the request stands until the rising edge that samples pready high
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            test_done();
        end
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        logic [31:0] rd;
        logic        ge;
        // write-once model: only the first write to each option register counts
        if (a == pwm_corr_pkg::CONFIG_OFS && cfg_m < 0) begin
            cfg_m = int'(d[1:0]);
        end
        if (a == pwm_corr_pkg::DEADTIME_OFS && dt_m < 0) begin
            dt_m = int'(d[7:0]);
        end
        apb(1'b1, a, d, rd, ge);
        chk_err(e, ge);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] v, input logic e, input string w);
        logic [31:0] rd;
        logic        ge;
        apb(1'b0, a, 32'h0, rd, ge);
        chk(w, v, rd);
        chk_err(e, ge);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        test_done();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            rdc(rst_a[i], rst_v[i], 1'b0, "reset value");
        end
        rdc(8'h14, 32'h0, 1'b1, "unmapped read");
        wr(pwm_corr_pkg::STATUS_OFS, 32'hFFF, 1'b1);
        wr(pwm_corr_pkg::CONFIG_OFS, 32'h1, 1'b0);
        wr(pwm_corr_pkg::CONFIG_OFS, 32'h2, 1'b0);
        rdc(pwm_corr_pkg::CONFIG_OFS, 32'(cfg_m), 1'b0, "polarity");
        repeat (8) @(posedge pclk);
        chk_pins("idle pins", {3{cfg_m[1:0]}});
        wr(pwm_corr_pkg::DEADTIME_OFS, 32'h4, 1'b0);
        wr(pwm_corr_pkg::DEADTIME_OFS, 32'h9, 1'b0);
        rdc(pwm_corr_pkg::DEADTIME_OFS, 32'(dt_m), 1'b0, "dead-time");
        wr(pwm_corr_pkg::MODULUS_OFS, 32'h10, 1'b0);
        // zero duty: only the cycle-point method may pick up the sense pins
        for (int c = 0; c < 2; c++) begin
            s = 3'($random(seed));
            neg_r  <= s;
            slow_r <= c[0];
            wr(pwm_corr_pkg::CTRL_OFS, 32'h19 | (32'(c) << 2), 1'b0);
            apb(1'b0, pwm_corr_pkg::STATUS_OFS, 32'h0, st, er);
            chk("first selection", 32'h0, {29'h0, st[11:9]});
            repeat (100) @(posedge pclk);
            rdc(pwm_corr_pkg::STATUS_OFS, {20'h0, s, s, 6'h0}, 1'b0, "cycle sense");
            wr(pwm_corr_pkg::CTRL_OFS, 32'h0, 1'b0);
        end
        s = 3'($random(seed));
        neg_r <= s;
        wr(pwm_corr_pkg::CTRL_OFS, 32'h19, 1'b0);
        repeat (100) @(posedge pclk);
        wr(pwm_corr_pkg::CTRL_OFS, 32'h11, 1'b0);
        neg_r <= ~s;
        repeat (100) @(posedge pclk);
        rdc(pwm_corr_pkg::STATUS_OFS, {20'h0, s, s, 6'h0}, 1'b0, "held sense");
        for (int i = 0; i < 6; i++) begin
            // odd registers longer, even ones shorter, by the edge-aligned dead-time
            wr(8'h20 + 8'(4 * i), 32'(8 + ((i % 2 == 0) ? dt_m : -dt_m)), 1'b0);
        end
        wr(pwm_corr_pkg::CTRL_OFS, 32'h111, 1'b0);
        repeat (100) @(posedge pclk);
        st = {20'h0, ~s, ~s, 6'h0};
        for (int p = 0; p < 3; p++) begin
            st[2 * p +: 2] = {2{~s[p]}};
        end
        rdc(pwm_corr_pkg::STATUS_OFS, st, 1'b0, "dead-time sense");
        for (int k = 0; k < 2; k++) begin
            s = (k == 0) ? ~neg_r : 3'($random(seed));
            wr(pwm_corr_pkg::CTRL_OFS, 32'h1 | (32'(k) << 3) | (32'(s) << 5), 1'b0);
            repeat (100) @(posedge pclk);
            apb(1'b0, pwm_corr_pkg::STATUS_OFS, 32'h0, st, er);
            chk("manual selection", {29'h0, s}, {29'h0, st[11:9]});
        end
        wr(pwm_corr_pkg::CTRL_OFS, 32'h0, 1'b0);
        apb(1'b0, pwm_corr_pkg::STATUS_OFS, 32'h0, st, er);
        chk("selection when off", 32'h0, {29'h0, st[11:9]});
        repeat (8) @(posedge pclk);
        chk_pins("idle pins", {3{cfg_m[1:0]}});
        test_done();
    end
endmodule // pwm_topbottom_correction_bench

`default_nettype wire
